// *** hdl/sixsw_regs.vh ***
// constants for the six channel low side switch diagnostic block
// What this block does
// - overload seen only while channel switched on
// - short to ground seen only while off
// - open load seen only while off
// - per stage over temperature only while on
// - store faults after nominal filter delay
// - newest filtered fault overwrites stored code
// - two bit code per channel in diagnostics
// - common over temperature bit latches OR of sensors of on stages
// - common fault bit for any output fault
// - fault held until diagnostic read, chip select rise or reset
// - overload limits current and sets code
// - overheated stage cycles off and restarts
// - strap selects parallel input polarity
// - floating parallel inputs leave channels off
// - floating strap reads low, active low inputs
// - under voltage forces all switches off
// - under voltage clears codes and serial control
// - external reset clears shift register, outputs off
// - serial on bit ANDed with parallel input
// - parallel enable bit selects parallel control
// - chip select rise loads buffers, clears diagnostics
`ifndef SIXSW_REGS_VH
`define SIXSW_REGS_VH

// ********************************************************
// register byte offsets
// ********************************************************
`define SIXSW_OFS_SER_STAGE 8'h00
`define SIXSW_OFS_SER_ACTIVE 8'h04
`define SIXSW_OFS_PAR_EN 8'h08
`define SIXSW_OFS_DIAG 8'h0c
`define SIXSW_OFS_STATUS 8'h10

// ********************************************************
// field positions and reset values
// ********************************************************
`define SIXSW_DIAG_OT_BIT 12
`define SIXSW_DIAG_FAULT_BIT 13
`define SIXSW_ST_THERM_LSB 6
`define SIXSW_ST_STRAP_BIT 12
`define SIXSW_ST_HOLD_BIT 13
`define SIXSW_RST_SER 6'h00
`define SIXSW_RST_PAR_EN 6'h00
`define SIXSW_RST_CODES 12'hfff

// ********************************************************
// fault codes
// ********************************************************
`define SIXSW_CODE_OVERLOAD 2'h0
`define SIXSW_CODE_SHORT_GND 2'h1
`define SIXSW_CODE_OPEN_LOAD 2'h2
`define SIXSW_CODE_OK 2'h3

// ********************************************************
// timing
// ********************************************************
`define SIXSW_CLK_MHZ 20
`define SIXSW_FILT_US 120
`define SIXSW_FILT_CYC (`SIXSW_FILT_US * `SIXSW_CLK_MHZ)
// last count of the filter wait: 2400 cycles of the clock, minus one
`define SIXSW_FILT_LAST 12'h95f

// ********************************************************
// bus answers
// ********************************************************
`define SIXSW_RESP_OKAY 2'h0
`define SIXSW_RESP_SLVERR 2'h2

`endif

// *** hdl/sixsw_filt.v ***
// fault filter for one channel: a code must stand unchanged for the filter time
`timescale 1ns/1ps
`include "sixsw_regs.vh"

module sixsw_filt (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// raw code of the channel, ok code when nothing is seen
	input wire [1:0] i_code,
	// one cycle pulse with the qualified code
	output reg o_store,
	output reg [1:0] o_code
);

	localparam [11:0] FILT_LAST = `SIXSW_FILT_LAST;

	reg [1:0] cand_reg;
	reg [11:0] cnt_reg;

	// ********************************************************
	// qualification counter
	// ********************************************************
	// any change of the raw code restarts the wait, so a fault that
	// replaces another one is stored only after its own full delay
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cand_reg <= `SIXSW_CODE_OK;
			cnt_reg <= 12'h000;
			o_store <= 1'b0;
			o_code <= `SIXSW_CODE_OK;
		end else begin
			o_store <= 1'b0;
			if (i_code != cand_reg) begin
				cand_reg <= i_code;
				cnt_reg <= 12'h000;
			end else if (cand_reg == `SIXSW_CODE_OK) begin
				cnt_reg <= 12'h000;
			end else if (cnt_reg == FILT_LAST) begin
				o_store <= 1'b1;
				o_code <= cand_reg;
				cnt_reg <= cnt_reg + 12'h001; // one pulse per episode
			end else if (cnt_reg < FILT_LAST) begin
				cnt_reg <= cnt_reg + 12'h001;
			end
		end
	end

endmodule

// *** hdl/sixsw_diag.v ***
// six channel low side switch control, protection and diagnostics
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sixsw_regs.vh"

module sixsw_diag (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// axi4-lite write address
	input wire i_axi_awvalid,
	output wire o_axi_awready,
	input wire [7:0] i_axi_awaddr,
	// axi4-lite write data
	input wire i_axi_wvalid,
	output wire o_axi_wready,
	input wire [31:0] i_axi_wdata,
	input wire [3:0] i_axi_wstrb,
	// axi4-lite write response
	output reg o_axi_bvalid,
	input wire i_axi_bready,
	output reg [1:0] o_axi_bresp,
	// axi4-lite read address
	input wire i_axi_arvalid,
	output wire o_axi_arready,
	input wire [7:0] i_axi_araddr,
	// axi4-lite read data
	output reg o_axi_rvalid,
	input wire i_axi_rready,
	output reg [31:0] o_axi_rdata,
	output reg [1:0] o_axi_rresp,
	// device pins, asynchronous to the clock
	input wire [5:0] i_parallel_input_pin,
	input wire i_input_polarity_strap,
	input wire i_ext_reset_n,
	input wire i_undervoltage,
	input wire i_chip_select_n,
	// analogue comparators and sensors, one bit per channel
	input wire [5:0] i_short_to_battery,
	input wire [5:0] i_short_to_ground,
	input wire [5:0] i_open_load,
	input wire [5:0] i_over_temperature,
	// power stage control
	output reg [5:0] o_power_output_pin,
	output reg [5:0] o_current_limit,
	output reg o_input_pull_up,
	output reg o_fault_n
);

	localparam SYNC_W = 34;

	// ********************************************************
	// address decode
	// ********************************************************
	// shared by the read and the write path so both agree on the map
	function sixsw_mapped;
		input [7:0] a;
		begin
			sixsw_mapped = (a == `SIXSW_OFS_SER_STAGE) ||
				(a == `SIXSW_OFS_SER_ACTIVE) ||
				(a == `SIXSW_OFS_PAR_EN) ||
				(a == `SIXSW_OFS_DIAG) ||
				(a == `SIXSW_OFS_STATUS);
		end
	endfunction

	// ********************************************************
	// input synchronisers
	// ********************************************************
	reg [SYNC_W-1:0] sync1_reg;
	reg [SYNC_W-1:0] sync2_reg;
	wire [SYNC_W-1:0] pins_raw;

	assign pins_raw = {i_parallel_input_pin, i_short_to_battery, i_short_to_ground,
		i_open_load, i_over_temperature, i_input_polarity_strap,
		i_ext_reset_n, i_undervoltage, i_chip_select_n};

	// reset values are the idle levels: reset pin high, select high
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_reg <= 34'h000000005;
			sync2_reg <= 34'h000000005;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	wire [5:0] par_pin_s = sync2_reg[33:28];
	wire [5:0] sbat_s = sync2_reg[27:22];
	wire [5:0] sgnd_s = sync2_reg[21:16];
	wire [5:0] oload_s = sync2_reg[15:10];
	wire [5:0] otemp_s = sync2_reg[9:4];
	wire strap_s = sync2_reg[3];
	wire ext_rst_n_s = sync2_reg[2];
	wire uv_s = sync2_reg[1];
	wire cs_n_s = sync2_reg[0];

	// external reset and under voltage act alike on the logic
	wire hold_rst = !ext_rst_n_s || uv_s;

	// ********************************************************
	// chip select edge
	// ********************************************************
	reg cs_n_d_reg;
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cs_n_d_reg <= 1'b1;
		end else begin
			cs_n_d_reg <= cs_n_s;
		end
	end
	wire cs_rise = cs_n_s && !cs_n_d_reg;

	// ********************************************************
	// axi4-lite slave
	// ********************************************************
	reg aw_held_reg;
	reg w_held_reg;
	reg [7:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg [5:0] ser_stage_reg;
	reg [5:0] ser_active_reg;
	reg [5:0] par_en_reg;
	reg [11:0] code_reg;
	reg ot_reg;
	reg fault_reg;
	reg [5:0] therm_off_reg;
	reg [31:0] rdata_next;
	reg diagnostic_read_command;

	assign o_axi_awready = !aw_held_reg;
	assign o_axi_wready = !w_held_reg;
	assign o_axi_arready = !o_axi_rvalid;

	wire aw_take = i_axi_awvalid && !aw_held_reg;
	wire w_take = i_axi_wvalid && !w_held_reg;
	wire wr_do = aw_held_reg && w_held_reg && !o_axi_bvalid;
	wire ar_take = i_axi_arvalid && !o_axi_rvalid;
	wire wr_low = wr_do && wstrb_reg[0];

	// address and data may come in either order; each is held until both are
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp <= `SIXSW_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= i_axi_awaddr;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= i_axi_wdata;
				wstrb_reg <= i_axi_wstrb;
			end
			if (wr_do) begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp <= sixsw_mapped(awaddr_reg) ? `SIXSW_RESP_OKAY :
					`SIXSW_RESP_SLVERR;
			end else if (o_axi_bvalid && i_axi_bready) begin
				o_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// read mux; unmapped addresses answer zero with an error
	always @* begin
		rdata_next = 32'h00000000;
		diagnostic_read_command = 1'b0;
		if (i_axi_araddr == `SIXSW_OFS_SER_STAGE) begin
			rdata_next[5:0] = ser_stage_reg;
		end else if (i_axi_araddr == `SIXSW_OFS_SER_ACTIVE) begin
			rdata_next[5:0] = ser_active_reg;
		end else if (i_axi_araddr == `SIXSW_OFS_PAR_EN) begin
			rdata_next[5:0] = par_en_reg;
		end else if (i_axi_araddr == `SIXSW_OFS_DIAG) begin
			rdata_next[11:0] = code_reg;
			rdata_next[`SIXSW_DIAG_OT_BIT] = ot_reg;
			rdata_next[`SIXSW_DIAG_FAULT_BIT] = fault_reg;
			diagnostic_read_command = ar_take;
		end else if (i_axi_araddr == `SIXSW_OFS_STATUS) begin
			rdata_next[5:0] = o_power_output_pin;
			rdata_next[11:6] = therm_off_reg;
			rdata_next[`SIXSW_ST_STRAP_BIT] = strap_s;
			rdata_next[`SIXSW_ST_HOLD_BIT] = hold_rst;
		end
	end

	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_axi_rvalid <= 1'b0;
			o_axi_rdata <= 32'h00000000;
			o_axi_rresp <= `SIXSW_RESP_OKAY;
		end else if (ar_take) begin
			o_axi_rvalid <= 1'b1;
			o_axi_rdata <= rdata_next;
			o_axi_rresp <= sixsw_mapped(i_axi_araddr) ? `SIXSW_RESP_OKAY :
				`SIXSW_RESP_SLVERR;
		end else if (o_axi_rvalid && i_axi_rready) begin
			o_axi_rvalid <= 1'b0;
		end
	end

	// ********************************************************
	// control registers
	// ********************************************************
	// the staged serial bits stand for the shift register: they are
	// moved to the active buffer only on the chip select rise
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ser_stage_reg <= `SIXSW_RST_SER;
			ser_active_reg <= `SIXSW_RST_SER;
			par_en_reg <= `SIXSW_RST_PAR_EN;
		end else if (hold_rst) begin
			ser_stage_reg <= `SIXSW_RST_SER;
			ser_active_reg <= `SIXSW_RST_SER;
			par_en_reg <= `SIXSW_RST_PAR_EN;
		end else begin
			if (wr_low && awaddr_reg == `SIXSW_OFS_SER_STAGE) begin
				ser_stage_reg <= wdata_reg[5:0];
			end
			if (wr_low && awaddr_reg == `SIXSW_OFS_PAR_EN) begin
				par_en_reg <= wdata_reg[5:0];
			end
			if (cs_rise) begin
				ser_active_reg <= ser_stage_reg;
			end
		end
	end

	// ********************************************************
	// channel drive
	// ********************************************************
	// the pull choice makes a floating pin read as inactive for
	// either polarity; the strap itself relies on its own pull down
	wire [5:0] par_act = strap_s ? par_pin_s : ~par_pin_s;
	reg [5:0] drive_next;

	always @* begin
		drive_next = 6'h00;
		if (!hold_rst) begin
			drive_next = (par_en_reg & par_act) |
				(~par_en_reg & ser_active_reg & par_act);
		end
		drive_next = drive_next & ~therm_off_reg;
	end

	// thermal shutdown follows the stage sensor with its own hysteresis,
	// so an overloaded output pulses at a low duty cycle
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			therm_off_reg <= 6'h00;
		end else begin
			therm_off_reg <= (therm_off_reg | (o_power_output_pin & otemp_s)) &
				otemp_s;
		end
	end

	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_power_output_pin <= 6'h00;
			o_current_limit <= 6'h00;
			o_input_pull_up <= 1'b1;
		end else begin
			o_power_output_pin <= drive_next;
			o_current_limit <= drive_next & sbat_s;
			o_input_pull_up <= !strap_s;
		end
	end

	// ********************************************************
	// fault detection and filtering
	// ********************************************************
	// the on state is the driven state; a comparator only counts in
	// the switch state where its result means anything
	wire [5:0] sw_on = o_power_output_pin;
	wire [5:0] store;
	wire [11:0] filt_code;
	reg [11:0] raw_code;
	integer i;

	always @* begin
		raw_code = `SIXSW_RST_CODES;
		for (i = 0; i < 6; i = i + 1) begin
			if (sw_on[i] && sbat_s[i]) begin
				raw_code[2*i +: 2] = `SIXSW_CODE_OVERLOAD;
			end else if (!sw_on[i] && sgnd_s[i]) begin
				raw_code[2*i +: 2] = `SIXSW_CODE_SHORT_GND;
			end else if (!sw_on[i] && oload_s[i]) begin
				raw_code[2*i +: 2] = `SIXSW_CODE_OPEN_LOAD;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_filt
			sixsw_filt u_filt (
				.i_sys_clk(i_sys_clk),
				.i_reset_n(i_reset_n),
				.i_code(raw_code[2*g +: 2]),
				.o_store(store[g]),
				.o_code(filt_code[2*g +: 2])
			);
		end
	endgenerate

	// ********************************************************
	// diagnostic store
	// ********************************************************
	// a fault qualified in the same cycle as a clear survives it
	wire diag_clr = diagnostic_read_command || cs_rise || hold_rst;
	wire [5:0] ot_on = sw_on & otemp_s;
	reg [11:0] code_next;
	integer j;

	always @* begin
		code_next = code_reg;
		if (diag_clr) begin
			code_next = `SIXSW_RST_CODES;
		end
		for (j = 0; j < 6; j = j + 1) begin
			if (store[j]) begin
				code_next[2*j +: 2] = filt_code[2*j +: 2];
			end
		end
	end

	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			code_reg <= `SIXSW_RST_CODES;
			ot_reg <= 1'b0;
			fault_reg <= 1'b0;
			o_fault_n <= 1'b1;
		end else begin
			code_reg <= code_next;
			ot_reg <= (|ot_on) || (ot_reg && !diag_clr);
			fault_reg <= (|store) || (|ot_on) || (fault_reg && !diag_clr);
			o_fault_n <= !((|store) || (|ot_on) || (fault_reg && !diag_clr));
		end
	end

endmodule

// *** tb/sixsw_chk_sva.sv ***
// port checker for the six channel switch diagnostic block
`timescale 1ns/1ps
module sixsw_chk (
	// clock and reset
	input logic i_sys_clk,
	input logic i_reset_n,
	// register bus handshakes
	input logic i_axi_awvalid,
	input logic o_axi_awready,
	input logic i_axi_wvalid,
	input logic o_axi_wready,
	input logic o_axi_bvalid,
	input logic i_axi_bready,
	input logic i_axi_arvalid,
	input logic o_axi_arready,
	input logic o_axi_rvalid,
	input logic i_axi_rready,
	// device pins and stage control
	input logic [5:0] i_parallel_input_pin,
	input logic i_input_polarity_strap,
	input logic i_ext_reset_n,
	input logic i_undervoltage,
	input logic i_chip_select_n,
	input logic [5:0] i_over_temperature,
	input logic [5:0] o_power_output_pin,
	input logic o_input_pull_up,
	input logic o_fault_n
);
	// ********
	// properties
	// ********
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	// no select rise, reset, low supply or read that could clear the fault
	sequence s_calm;
		(i_chip_select_n && i_ext_reset_n && !i_undervoltage && !i_axi_arvalid)[*4];
	endsequence
	sequence s_wr_taken;
		i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
	endsequence
	a_fault_held: assert property ((s_calm ##0 !o_fault_n) ##1 s_calm |-> !o_fault_n)
		else $error("fault flag dropped with no clearing cause");
	a_uv_off: assert property (i_undervoltage[*6] |-> o_power_output_pin == 6'h00)
		else $error("switch on during low supply");
	a_xrst_off: assert property ((!i_ext_reset_n)[*6] |-> o_power_output_pin == 6'h00)
		else $error("switch on during external reset");
	a_floating_off: assert property ((!i_input_polarity_strap && &i_parallel_input_pin)[*7]
		|-> o_power_output_pin == 6'h00)
		else $error("switch on with inputs pulled inactive");
	a_high_active_off: assert property ((i_input_polarity_strap && i_parallel_input_pin == 6'h00)[*7]
		|-> o_power_output_pin == 6'h00)
		else $error("switch on with high active inputs low");
	a_pull_follow: assert property ($stable(i_input_polarity_strap)[*5]
		|-> o_input_pull_up == !i_input_polarity_strap)
		else $error("input pull direction does not follow strap");
	a_hot_off: assert property (i_over_temperature[0][*8] |-> !o_power_output_pin[0])
		else $error("hot stage still switched on");
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] o_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
		else $error("read not answered");
	a_read_refuse: assert property (o_axi_rvalid |-> !o_axi_arready)
		else $error("read address taken while answer pending");
	a_read_clear: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid)
		else $error("read answer stays after it was taken");
	a_write_clear: assert property (o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid)
		else $error("write answer stays after it was taken");
endmodule
bind sixsw_diag sixsw_chk u_chk (.*);

// *** tb/sixsw_host.sv ***
// host model: frames the select line and keeps the pause between transfers
`timescale 1ns/1ps
module sixsw_host #(parameter int FRAME = 128, parameter int GAP = 4000) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// frame request from the bench
	input wire i_go,
	// select towards the block, idle when a new frame may start
	output logic o_cs_n,
	output logic o_idle
);
	int cnt;
	// one count spans the frame and the pause; requests in the pause are dropped
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cs_n <= 1'h1;
			cnt <= 0;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == GAP + 1)
				o_cs_n <= 1'h1;
		end else if (i_go) begin
			o_cs_n <= 1'h0;
			cnt <= FRAME + GAP;
		end
	end
	// a pause of 200 us lets the filters settle before the next read
	assign o_idle = cnt == 0 && o_cs_n;
endmodule

// *** tb/test_six_channel_switch_diagnostics.sv ***
// self-checking bench for the six channel switch diagnostic block
`timescale 1ns/1ps
`include "sixsw_regs.vh"
module test_six_channel_switch_diagnostics;
	// ********
	// stimulus and observed signals
	// ********
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0, go = 1'h0;
	logic strap = 1'h0, xrst_n = 1'h1, uv = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, got;
	logic [5:0] pins = 6'h3f, sbat = 6'h00, sgnd = 6'h00, ol = 6'h00, ot = 6'h00;
	logic [1:0] resp;
	wire awr, wr_rdy, bv, arr, rv, cs_n, idle, pull_up, fault_n;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [5:0] out, ilim;
	int bad_count = 0;
	int n_compared = 0;
	sixsw_diag DUT (
		.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa),
		.i_axi_wvalid(wv), .o_axi_wready(wr_rdy), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
		.o_axi_bvalid(bv), .i_axi_bready(bready), .o_axi_bresp(bresp),
		.i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
		.o_axi_rvalid(rv), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
		.i_parallel_input_pin(pins), .i_input_polarity_strap(strap), .i_ext_reset_n(xrst_n),
		.i_undervoltage(uv), .i_chip_select_n(cs_n), .i_short_to_battery(sbat),
		.i_short_to_ground(sgnd), .i_open_load(ol), .i_over_temperature(ot),
		.o_power_output_pin(out), .o_current_limit(ilim), .o_input_pull_up(pull_up),
		.o_fault_n(fault_n)
	);
	sixsw_host u_host (.i_sys_clk(clk), .i_reset_n(rst_n), .i_go(go), .o_cs_n(cs_n), .o_idle(idle));
	// ********
	// shared tasks
	// ********
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// readies are looked at mid-cycle so the decision never races the edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, pr, ta, tw;
		int n;
		@(posedge clk);
		awa <= a;
		ara <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		arv <= !w;
		bready <= w;
		rready <= !w;
		pa = 1'h1;
		pw = w;
		pr = 1'h1;
		for (n = 0; n < 60 && pr; n++) begin
			@(negedge clk);
			ta = pa && (w ? awr : arr);
			tw = pw && wr_rdy;
			if (w ? bv : rv) begin
				pr = 1'h0;
				resp = w ? bresp : rresp;
				got = rdata;
			end
			@(posedge clk);
			if (ta) begin
				awv <= 1'h0;
				arv <= 1'h0;
				pa = 1'h0;
			end
			if (tw) begin
				wv <= 1'h0;
				pw = 1'h0;
			end
			if (!pr) begin
				bready <= 1'h0;
				rready <= 1'h0;
			end
		end
		if (pr)
			chk("bus answer", 32'h1, 32'h0);
		else if (w)
			chk("write response", 32'h0, {30'h0, resp});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bus(1'h0, a, 32'h0);
		chk($sformatf("register %h", a), e, got);
		chk("response", {30'h0, er}, {30'h0, resp});
	endtask
	task automatic see_out(input logic [5:0] e);
		int n;
		for (n = 0; n < 20 && out !== e; n++)
			@(negedge clk);
		chk("outputs", {26'h0, e}, {26'h0, out});
	endtask
	// waits out the host pause, then for the end of the frame
	task automatic frame;
		int n;
		for (n = 0; n < 5000 && !idle; n++)
			@(negedge clk);
		@(posedge clk);
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		for (n = 0; n < 400 && !(cs_n && !idle); n++)
			@(negedge clk);
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_reset;
		see_out(6'h00);
		chk("pull up", 32'h1, pull_up);
		rdchk(`SIXSW_OFS_DIAG, 32'h0fff, `SIXSW_RESP_OKAY);
		rdchk(8'h14, 32'h0, `SIXSW_RESP_SLVERR);
		bus(1'h1, `SIXSW_OFS_DIAG, 32'h0);
		rdchk(`SIXSW_OFS_DIAG, 32'h0fff, `SIXSW_RESP_OKAY);
		$display("test reset done");
	endtask
	task automatic t_drive;
		strap <= 1'h1;
		pins <= 6'h07;
		bus(1'h1, `SIXSW_OFS_SER_STAGE, 32'h05);
		frame;
		see_out(6'h05);
		chk("pull up", 32'h0, pull_up);
		bus(1'h1, `SIXSW_OFS_PAR_EN, 32'h3f);
		see_out(6'h07);
		strap <= 1'h0;
		see_out(6'h38);
		chk("pull up", 32'h1, pull_up);
		strap <= 1'h1;
		bus(1'h1, `SIXSW_OFS_PAR_EN, 32'h0);
		pins <= 6'h00;
		see_out(6'h00);
		pins <= 6'h07;
		see_out(6'h05);
		$display("test drive done");
	endtask
	// channel 1 on, channel 2 off from here
	task automatic t_filter;
		sbat <= 6'h01;
		hold(1000);
		sbat <= 6'h00;
		rdchk(`SIXSW_OFS_DIAG, 32'h0fff, `SIXSW_RESP_OKAY);
		sbat <= 6'h01;
		hold(5000);
		@(negedge clk);
		chk("current limit", 32'h01, ilim);
		chk("fault pin", 32'h0, fault_n);
		@(posedge clk);
		sbat <= 6'h00;
		rdchk(`SIXSW_OFS_DIAG, 32'h2ffc, `SIXSW_RESP_OKAY);
		rdchk(`SIXSW_OFS_DIAG, 32'h0fff, `SIXSW_RESP_OKAY);
		$display("test filter done");
	endtask
	task automatic t_state;
		sgnd <= 6'h01;
		ol <= 6'h01;
		sbat <= 6'h02;
		ot <= 6'h02;
		hold(5000);
		sgnd <= 6'h00;
		ol <= 6'h00;
		sbat <= 6'h00;
		ot <= 6'h00;
		rdchk(`SIXSW_OFS_DIAG, 32'h0fff, `SIXSW_RESP_OKAY);
		ol <= 6'h02;
		hold(5000);
		ol <= 6'h00;
		sgnd <= 6'h02;
		hold(5000);
		sgnd <= 6'h00;
		rdchk(`SIXSW_OFS_DIAG, 32'h2ff7, `SIXSW_RESP_OKAY);
		$display("test state done");
	endtask
	task automatic t_temp;
		ot <= 6'h01;
		see_out(6'h04);
		hold(10);
		ot <= 6'h00;
		see_out(6'h05);
		rdchk(`SIXSW_OFS_DIAG, 32'h3fff, `SIXSW_RESP_OKAY);
		$display("test temperature done");
	endtask
	task automatic t_clear;
		ol <= 6'h02;
		hold(5000);
		ol <= 6'h00;
		uv <= 1'h1;
		see_out(6'h00);
		@(posedge clk);
		uv <= 1'h0;
		rdchk(`SIXSW_OFS_DIAG, 32'h0fff, `SIXSW_RESP_OKAY);
		rdchk(`SIXSW_OFS_SER_STAGE, 32'h0, `SIXSW_RESP_OKAY);
		rdchk(`SIXSW_OFS_SER_ACTIVE, 32'h0, `SIXSW_RESP_OKAY);
		bus(1'h1, `SIXSW_OFS_SER_STAGE, 32'h05);
		frame;
		see_out(6'h05);
		xrst_n <= 1'h0;
		see_out(6'h00);
		@(posedge clk);
		xrst_n <= 1'h1;
		rdchk(`SIXSW_OFS_SER_STAGE, 32'h0, `SIXSW_RESP_OKAY);
		$display("test clear done");
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ********
	// clock, sequence and watchdog
	// ********
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		hold(20);
		rst_n <= 1'h1;
		t_reset;
		t_drive;
		t_filter;
		t_state;
		t_temp;
		t_clear;
		test_done;
	end
	// the run needs about 27000 cycles; three times that means a hang
	initial begin
		#4000000;
		bad_count++;
		test_done;
	end
endmodule
